// ---- rtl/pee_top.sv ----
// Top: packs per-port event groups into the registered event vector
`timescale 1ns/1ps
// Function
// - Each event identified by 8 bits: 3-bit source above 5-bit number.
// - Sources 0 to 4 are slave ports, 5 to 7 master ports.
// - With secure counting disabled, only non-secure events are recorded.
// - With secure counting enabled, secure and non-secure events both pass.
// - Master events 2 and 9 to 16 pass regardless of secure enable.
// - Slave read handshakes raise events 0 to 8 by request kind.
// - Slave read stall on full read tracker raises event 9.
// - Last read data from snoop raises slave event 10.
// - Read valid high with ready low raises slave event 11 each cycle.
// - Slave write handshakes raise events 12 to 18 by request kind.
// - Slave write stall on full write tracker raises event 19.
// - Slave read stall on ID hazard raises event 20.
// - Master retry scheduling raises event 0, once even for two retries.
// - Master read stall on address hazard event 1, ID hazard event 2.
// - Master read queue stalls: high priority 3, low 7, medium 8.
// - Master barrier hazard stalls: read event 4, write event 5.
// - Master write tracker full stall raises event 6.
// - Master token waits: reads events 9 to 12, writes 13 to 16.
// - Unique write stall on address hazard raises master event 17.
// - Each triggered event drives its vector bit high one cycle.
// - Inside a group, an event sits at the bit of its number.
// - Slave ports 0, 1, 2 take bits 20:0, 41:21, 62:42.
// - The exported event vector is 159 bits wide.
// - Monitor enable low suppresses both counting and export.
module pee_top
  import pee_pkg::*;
#(
  parameter int NUM_SLV = pee_pkg::PEE_NUM_SLV,
  parameter int NUM_MST = pee_pkg::PEE_NUM_MST
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic noninvasive_monitor_enable_in,
  input wire logic secure_count_enable_in,
  // Slave-side event sources, one bit or field per port
  input wire logic [NUM_SLV-1:0] s_rd_hs_in,
  input wire logic [NUM_SLV*pee_pkg::PEE_S_RD_KINDS-1:0] s_rd_kind_in,
  input wire logic [NUM_SLV-1:0] s_rd_secure_in,
  input wire logic [NUM_SLV-1:0] s_rd_trk_stall_in,
  input wire logic [NUM_SLV-1:0] s_rd_id_haz_stall_in,
  input wire logic [NUM_SLV-1:0] s_rdata_last_hs_in,
  input wire logic [NUM_SLV-1:0] s_rdata_from_snoop_in,
  input wire logic [NUM_SLV-1:0] s_rdata_secure_in,
  input wire logic [NUM_SLV-1:0] slave_port_read_valid_in,
  input wire logic [NUM_SLV-1:0] slave_port_read_ready_in,
  input wire logic [NUM_SLV-1:0] s_wr_hs_in,
  input wire logic [NUM_SLV*(pee_pkg::PEE_S_WR_KINDS-1)-1:0] s_wr_kind_in,
  input wire logic [NUM_SLV-1:0] s_wr_secure_in,
  input wire logic [NUM_SLV-1:0] s_wr_trk_stall_in,
  // Master-side event sources
  input wire logic [NUM_MST*2-1:0] m_retry_sched_in,
  input wire logic [NUM_MST-1:0] m_retry_secure_in,
  input wire logic [NUM_MST-1:0] m_rd_addr_haz_in,
  input wire logic [NUM_MST-1:0] m_rd_id_haz_in,
  input wire logic [NUM_MST-1:0] m_rd_hi_full_in,
  input wire logic [NUM_MST-1:0] m_rd_bar_haz_in,
  input wire logic [NUM_MST-1:0] m_wr_bar_haz_in,
  input wire logic [NUM_MST-1:0] m_wr_trk_full_in,
  input wire logic [NUM_MST-1:0] m_rd_lo_full_in,
  input wire logic [NUM_MST-1:0] m_rd_med_full_in,
  input wire logic [NUM_MST*pee_pkg::PEE_NUM_VN-1:0] m_rd_vn_wait_in,
  input wire logic [NUM_MST*pee_pkg::PEE_NUM_VN-1:0] m_wr_vn_wait_in,
  input wire logic [NUM_MST-1:0] m_wu_addr_haz_in,
  input wire logic [NUM_MST-1:0] m_rd_secure_in,
  input wire logic [NUM_MST-1:0] m_wr_secure_in,
  // Counter selection: 8-bit {source,number} identifier
  input wire logic [pee_pkg::PEE_ID_W-1:0] count_select_in,
  output logic [pee_pkg::PEE_VEC_W-1:0] perf_event_vector_out,
  output logic count_event_out
);
  import pee_pkg::*;

  localparam int VEC_W = NUM_SLV * PEE_SLV_EVT_W + NUM_MST * PEE_MST_EVT_W;
  localparam int MST_BASE = NUM_SLV * PEE_SLV_EVT_W;

  logic [VEC_W-1:0] vec_comb;
  logic [VEC_W-1:0] perf_event_vector_r;
  logic [VEC_W-1:0] perf_event_vector_nxt;
  logic count_event_r;
  logic count_event_nxt;
  logic [PEE_SRC_W-1:0] sel_src;
  logic [PEE_NUM_W-1:0] sel_num;

  // ------------------------------------------------------------
  // Slave-side groups, 21 bits each from bit 0 upward
  // ------------------------------------------------------------
  for (genvar s = 0; s < NUM_SLV; s++) begin : g_slv
    pee_slave_group u_grp (
      .rd_hs_in(s_rd_hs_in[s]),
      .rd_kind_in(s_rd_kind_in[s*PEE_S_RD_KINDS +: PEE_S_RD_KINDS]),
      .rd_secure_in(s_rd_secure_in[s]),
      .rd_trk_stall_in(s_rd_trk_stall_in[s]),
      .rd_id_haz_stall_in(s_rd_id_haz_stall_in[s]),
      .rdata_last_hs_in(s_rdata_last_hs_in[s]),
      .rdata_from_snoop_in(s_rdata_from_snoop_in[s]),
      .rdata_secure_in(s_rdata_secure_in[s]),
      .slave_port_read_valid_in(slave_port_read_valid_in[s]),
      .slave_port_read_ready_in(slave_port_read_ready_in[s]),
      .wr_hs_in(s_wr_hs_in[s]),
      .wr_kind_in(s_wr_kind_in[s*(PEE_S_WR_KINDS-1) +: PEE_S_WR_KINDS-1]),
      .wr_secure_in(s_wr_secure_in[s]),
      .wr_trk_stall_in(s_wr_trk_stall_in[s]),
      .allow_secure_in(secure_count_enable_in),
      .events_out(vec_comb[s*PEE_SLV_EVT_W +: PEE_SLV_EVT_W])
    );
  end

  // ------------------------------------------------------------
  // Master-side groups, 18 bits each above the slave groups
  // ------------------------------------------------------------
  for (genvar m = 0; m < NUM_MST; m++) begin : g_mst
    pee_master_group u_grp (
      .retry_sched_in(m_retry_sched_in[m*2 +: 2]),
      .retry_secure_in(m_retry_secure_in[m]),
      .rd_addr_haz_in(m_rd_addr_haz_in[m]),
      .rd_id_haz_in(m_rd_id_haz_in[m]),
      .rd_hi_full_in(m_rd_hi_full_in[m]),
      .rd_bar_haz_in(m_rd_bar_haz_in[m]),
      .wr_bar_haz_in(m_wr_bar_haz_in[m]),
      .wr_trk_full_in(m_wr_trk_full_in[m]),
      .rd_lo_full_in(m_rd_lo_full_in[m]),
      .rd_med_full_in(m_rd_med_full_in[m]),
      .rd_vn_wait_in(m_rd_vn_wait_in[m*PEE_NUM_VN +: PEE_NUM_VN]),
      .wr_vn_wait_in(m_wr_vn_wait_in[m*PEE_NUM_VN +: PEE_NUM_VN]),
      .wu_addr_haz_in(m_wu_addr_haz_in[m]),
      .rd_secure_in(m_rd_secure_in[m]),
      .wr_secure_in(m_wr_secure_in[m]),
      .allow_secure_in(secure_count_enable_in),
      .events_out(vec_comb[MST_BASE + m*PEE_MST_EVT_W +: PEE_MST_EVT_W])
    );
  end

  // ------------------------------------------------------------
  // Monitor gating and counter selection
  // ------------------------------------------------------------
  // Selection decodes source then number; unused numbers select nothing
  always_comb begin
    sel_src = count_select_in[PEE_ID_W-1 -: PEE_SRC_W];
    sel_num = count_select_in[PEE_NUM_W-1:0];
    perf_event_vector_nxt = noninvasive_monitor_enable_in ? vec_comb : '0;
    count_event_nxt = 1'b0;
    if (sel_src <= PEE_SRC_SLV_LAST) begin
      if (32'(sel_num) < PEE_SLV_EVT_W) begin
        count_event_nxt = perf_event_vector_nxt[32'(sel_src) * PEE_SLV_EVT_W + 32'(sel_num)];
      end
    end else if (32'(sel_num) < PEE_MST_EVT_W) begin
      count_event_nxt = perf_event_vector_nxt[MST_BASE
                        + (32'(sel_src) - 32'(PEE_SRC_MST0)) * PEE_MST_EVT_W + 32'(sel_num)];
    end
  end

  // Registered so each pulse lasts exactly one clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      perf_event_vector_r <= '0;
      count_event_r <= 1'b0;
    end else begin
      perf_event_vector_r <= perf_event_vector_nxt;
      count_event_r <= count_event_nxt;
    end
  end

  assign perf_event_vector_out = perf_event_vector_r;
  assign count_event_out = count_event_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_rd_handshake(int p);
    noninvasive_monitor_enable_in && s_rd_hs_in[p] && !s_rd_secure_in[p];
  endsequence

  a_vec_width: assert property (@(posedge clk_in) disable iff (rst_in)
    $bits(perf_event_vector_out) == 159) else $error("event vector width wrong");

  a_monitor_off: assert property (@(posedge clk_in) disable iff (rst_in)
    !noninvasive_monitor_enable_in |=> perf_event_vector_out == '0)
    else $error("events exported while monitor disabled");

  a_slv0_rd_any: assert property (@(posedge clk_in) disable iff (rst_in)
    s_rd_handshake(0) |=> perf_event_vector_out[PEE_S_RD_ANY])
    else $error("slave 0 read handshake event missing");

  a_slv2_stall: assert property (@(posedge clk_in) disable iff (rst_in)
    noninvasive_monitor_enable_in && slave_port_read_valid_in[2] && !slave_port_read_ready_in[2]
    && !s_rdata_secure_in[2] |=> perf_event_vector_out[2*PEE_SLV_EVT_W + PEE_S_RD_DATA_STALL])
    else $error("slave 2 read data stall event missing");

  a_secure_block: assert property (@(posedge clk_in) disable iff (rst_in)
    !secure_count_enable_in && s_rd_hs_in[4] && s_rd_secure_in[4]
    |=> !perf_event_vector_out[4*PEE_SLV_EVT_W + PEE_S_RD_ANY])
    else $error("secure read event leaked");

  a_secure_pass: assert property (@(posedge clk_in) disable iff (rst_in)
    noninvasive_monitor_enable_in && secure_count_enable_in && s_wr_hs_in[3]
    |=> perf_event_vector_out[3*PEE_SLV_EVT_W + PEE_S_WR_ANY])
    else $error("secure write event dropped");

  a_mst_unqual: assert property (@(posedge clk_in) disable iff (rst_in)
    noninvasive_monitor_enable_in && m_rd_id_haz_in[2]
    |=> perf_event_vector_out[PEE_MST_BASE + 2*PEE_MST_EVT_W + PEE_M_RD_ID_HAZ])
    else $error("unqualified master event dropped");

  a_mst2_wu_haz: assert property (@(posedge clk_in) disable iff (rst_in)
    noninvasive_monitor_enable_in && m_wu_addr_haz_in[2] && !m_wr_secure_in[2]
    |=> perf_event_vector_out[VEC_W-1])
    else $error("master 2 unique write hazard event missing");

  a_pulse_single: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(perf_event_vector_out[PEE_S_RD_ANY]) && !s_rd_hs_in[0]
    |=> !perf_event_vector_out[PEE_S_RD_ANY])
    else $error("event pulse held too long");

  a_count_sel: assert property (@(posedge clk_in) disable iff (rst_in)
    noninvasive_monitor_enable_in && count_select_in == 8'hCA && m_rd_vn_wait_in[5]
    |=> count_event_out) else $error("selected master 1 event not counted");
endmodule : pee_top

// ---- rtl/pee_pkg.sv ----
// Package: event codes, vector layout and group widths for the event encoder
package pee_pkg;
  // ------------------------------------------------------------
  // Source codes and event identifier layout
  // ------------------------------------------------------------
  localparam int PEE_SRC_W = 3;
  localparam int PEE_NUM_W = 5;
  localparam int PEE_ID_W = PEE_SRC_W + PEE_NUM_W;
  localparam int PEE_NUM_SLV = 5;
  localparam int PEE_NUM_MST = 3;
  localparam int PEE_NUM_SRC = PEE_NUM_SLV + PEE_NUM_MST;
  localparam logic [PEE_SRC_W-1:0] PEE_SRC_SLV0 = 3'h0;
  localparam logic [PEE_SRC_W-1:0] PEE_SRC_SLV_LAST = 3'h4;
  localparam logic [PEE_SRC_W-1:0] PEE_SRC_MST0 = 3'h5;
  localparam logic [PEE_SRC_W-1:0] PEE_SRC_MST_LAST = 3'h7;
  // ------------------------------------------------------------
  // Group widths and vector layout
  // ------------------------------------------------------------
  localparam int PEE_SLV_EVT_W = 21;
  localparam int PEE_MST_EVT_W = 18;
  localparam int PEE_VEC_W = PEE_NUM_SLV * PEE_SLV_EVT_W + PEE_NUM_MST * PEE_MST_EVT_W;
  localparam int PEE_MST_BASE = PEE_NUM_SLV * PEE_SLV_EVT_W;
  // Slave-side event numbers
  localparam int PEE_S_RD_ANY = 8'h00;
  localparam int PEE_S_RD_DVM_SYNC = 8'h08;
  localparam int PEE_S_RD_TRK_FULL = 8'h09;
  localparam int PEE_S_RD_SNOOP_DATA = 8'h0A;
  localparam int PEE_S_RD_DATA_STALL = 8'h0B;
  localparam int PEE_S_WR_ANY = 8'h0C;
  localparam int PEE_S_WR_EVICT = 8'h12;
  localparam int PEE_S_WR_TRK_FULL = 8'h13;
  localparam int PEE_S_RD_ID_HAZ = 8'h14;
  localparam int PEE_S_RD_KINDS = PEE_S_RD_DVM_SYNC - PEE_S_RD_ANY + 1;
  localparam int PEE_S_WR_KINDS = PEE_S_WR_EVICT - PEE_S_WR_ANY + 1;
  // Master-side event numbers
  localparam int PEE_M_RETRY = 8'h00;
  localparam int PEE_M_RD_ADDR_HAZ = 8'h01;
  localparam int PEE_M_RD_ID_HAZ = 8'h02;
  localparam int PEE_M_RD_HI_FULL = 8'h03;
  localparam int PEE_M_RD_BAR_HAZ = 8'h04;
  localparam int PEE_M_WR_BAR_HAZ = 8'h05;
  localparam int PEE_M_WR_TRK_FULL = 8'h06;
  localparam int PEE_M_RD_LO_FULL = 8'h07;
  localparam int PEE_M_RD_MED_FULL = 8'h08;
  localparam int PEE_M_RD_VN0 = 8'h09;
  localparam int PEE_M_WR_VN0 = 8'h0D;
  localparam int PEE_M_WR_VN_LAST = 8'h10;
  localparam int PEE_M_WU_ADDR_HAZ = 8'h11;
  localparam int PEE_NUM_VN = 4;
  // Master events that carry no security qualifier
  localparam logic [PEE_MST_EVT_W-1:0] PEE_M_UNQUAL_MASK = 18'h1FE04;
  localparam logic [PEE_VEC_W-1:0] PEE_VEC_RST = '0;
endpackage : pee_pkg

// ---- rtl/pee_slave_group.sv ----
// Slave-side event group: builds one port's 21-bit event word
`timescale 1ns/1ps
module pee_slave_group
  import pee_pkg::*;
(
  input wire logic rd_hs_in,
  input wire logic [pee_pkg::PEE_S_RD_KINDS-1:0] rd_kind_in,
  input wire logic rd_secure_in,
  input wire logic rd_trk_stall_in,
  input wire logic rd_id_haz_stall_in,
  input wire logic rdata_last_hs_in,
  input wire logic rdata_from_snoop_in,
  input wire logic rdata_secure_in,
  input wire logic slave_port_read_valid_in,
  input wire logic slave_port_read_ready_in,
  input wire logic wr_hs_in,
  input wire logic [pee_pkg::PEE_S_WR_KINDS-2:0] wr_kind_in,
  input wire logic wr_secure_in,
  input wire logic wr_trk_stall_in,
  input wire logic allow_secure_in,
  output logic [pee_pkg::PEE_SLV_EVT_W-1:0] events_out
);
  logic rd_ok;
  logic wr_ok;
  logic rdat_ok;

  // ------------------------------------------------------------
  // Security gating and placement by event number
  // ------------------------------------------------------------
  always_comb begin
    rd_ok = allow_secure_in | ~rd_secure_in;
    wr_ok = allow_secure_in | ~wr_secure_in;
    rdat_ok = allow_secure_in | ~rdata_secure_in;
    events_out = '0;
    // Read handshake: 'any' plus the one classified kind
    events_out[PEE_S_RD_ANY] = rd_hs_in & rd_ok;
    for (int k = 1; k < PEE_S_RD_KINDS; k++) begin
      events_out[PEE_S_RD_ANY + k] = rd_hs_in & rd_kind_in[k] & rd_ok;
    end
    events_out[PEE_S_RD_TRK_FULL] = rd_trk_stall_in & rd_ok;
    events_out[PEE_S_RD_SNOOP_DATA] = rdata_last_hs_in & rdata_from_snoop_in & rdat_ok;
    // Valid high while the master refuses the beat
    events_out[PEE_S_RD_DATA_STALL] = slave_port_read_valid_in & ~slave_port_read_ready_in
                                      & rdat_ok;
    events_out[PEE_S_WR_ANY] = wr_hs_in & wr_ok;
    for (int k = 1; k < PEE_S_WR_KINDS; k++) begin
      events_out[PEE_S_WR_ANY + k] = wr_hs_in & wr_kind_in[k-1] & wr_ok;
    end
    events_out[PEE_S_WR_TRK_FULL] = wr_trk_stall_in & wr_ok;
    events_out[PEE_S_RD_ID_HAZ] = rd_id_haz_stall_in & rd_ok;
  end
endmodule : pee_slave_group

// ---- rtl/pee_master_group.sv ----
// Master-side event group: builds one port's 18-bit event word
`timescale 1ns/1ps
module pee_master_group
  import pee_pkg::*;
(
  input wire logic [1:0] retry_sched_in,
  input wire logic retry_secure_in,
  input wire logic rd_addr_haz_in,
  input wire logic rd_id_haz_in,
  input wire logic rd_hi_full_in,
  input wire logic rd_bar_haz_in,
  input wire logic wr_bar_haz_in,
  input wire logic wr_trk_full_in,
  input wire logic rd_lo_full_in,
  input wire logic rd_med_full_in,
  input wire logic [pee_pkg::PEE_NUM_VN-1:0] rd_vn_wait_in,
  input wire logic [pee_pkg::PEE_NUM_VN-1:0] wr_vn_wait_in,
  input wire logic wu_addr_haz_in,
  input wire logic rd_secure_in,
  input wire logic wr_secure_in,
  input wire logic allow_secure_in,
  output logic [pee_pkg::PEE_MST_EVT_W-1:0] events_out
);
  logic [PEE_MST_EVT_W-1:0] raw;
  logic [PEE_MST_EVT_W-1:0] sec;

  // ------------------------------------------------------------
  // Raw events, their security tag, then gating
  // ------------------------------------------------------------
  always_comb begin
    raw = '0;
    sec = '0;
    // Two retries in one cycle still give one event
    raw[PEE_M_RETRY] = |retry_sched_in;
    sec[PEE_M_RETRY] = retry_secure_in;
    raw[PEE_M_RD_ADDR_HAZ] = rd_addr_haz_in;
    raw[PEE_M_RD_ID_HAZ] = rd_id_haz_in;
    raw[PEE_M_RD_HI_FULL] = rd_hi_full_in;
    raw[PEE_M_RD_LO_FULL] = rd_lo_full_in;
    raw[PEE_M_RD_MED_FULL] = rd_med_full_in;
    raw[PEE_M_RD_BAR_HAZ] = rd_bar_haz_in;
    raw[PEE_M_WR_BAR_HAZ] = wr_bar_haz_in;
    raw[PEE_M_WR_TRK_FULL] = wr_trk_full_in;
    for (int v = 0; v < PEE_NUM_VN; v++) begin
      raw[PEE_M_RD_VN0 + v] = rd_vn_wait_in[v];
      raw[PEE_M_WR_VN0 + v] = wr_vn_wait_in[v];
    end
    raw[PEE_M_WU_ADDR_HAZ] = wu_addr_haz_in;
    sec[PEE_M_RD_ADDR_HAZ] = rd_secure_in;
    sec[PEE_M_RD_HI_FULL] = rd_secure_in;
    sec[PEE_M_RD_LO_FULL] = rd_secure_in;
    sec[PEE_M_RD_MED_FULL] = rd_secure_in;
    sec[PEE_M_RD_BAR_HAZ] = rd_secure_in;
    sec[PEE_M_WR_BAR_HAZ] = wr_secure_in;
    sec[PEE_M_WR_TRK_FULL] = wr_secure_in;
    sec[PEE_M_WU_ADDR_HAZ] = wr_secure_in;
    // Unqualified events ignore the secure enable
    sec = sec & ~PEE_M_UNQUAL_MASK;
    events_out = raw & (~sec | {PEE_MST_EVT_W{allow_secure_in}});
  end
endmodule : pee_master_group

// ---- tb/pee_event_monitor.sv ----
// Far-side model: an event counter that tallies every pulse on the event vector
`timescale 1ns/1ps
module pee_event_monitor
  import pee_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [pee_pkg::PEE_VEC_W-1:0] perf_event_vector_in,
  output logic [31:0] pulse_total_out
);
  logic [31:0] pulse_total_r;
  logic [31:0] pulse_total_nxt;
  // A bit high for one cycle is one event, so a held bit counts each cycle
  always_comb begin
    pulse_total_nxt = pulse_total_r + 32'($countones(perf_event_vector_in));
  end
  // Tally register, cleared with the encoder
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_total_r <= 32'h0;
    end else begin
      pulse_total_r <= pulse_total_nxt;
    end
  end
  assign pulse_total_out = pulse_total_r;
endmodule : pee_event_monitor

// ---- tb/pee_top_tb.sv ----
// Testbench for the event encoder: table of single events, then hand cases
`timescale 1ns/1ps
module pee_top_tb;
  import pee_pkg::*;
  localparam int NS = PEE_NUM_SLV;
  localparam int NM = PEE_NUM_MST;
  logic clk_in, rst_in, noninvasive_monitor_enable_in, secure_count_enable_in;
  logic [NS-1:0] s_rd_hs_in, s_rd_secure_in, s_rd_trk_stall_in, s_rd_id_haz_stall_in;
  logic [NS-1:0] s_rdata_last_hs_in, s_rdata_from_snoop_in, s_rdata_secure_in;
  logic [NS-1:0] slave_port_read_valid_in, slave_port_read_ready_in, s_wr_hs_in;
  logic [NS-1:0] s_wr_secure_in, s_wr_trk_stall_in;
  logic [NS*PEE_S_RD_KINDS-1:0] s_rd_kind_in;
  logic [NS*(PEE_S_WR_KINDS-1)-1:0] s_wr_kind_in;
  logic [NM*2-1:0] m_retry_sched_in;
  logic [NM-1:0] m_retry_secure_in, m_rd_addr_haz_in, m_rd_id_haz_in, m_rd_hi_full_in;
  logic [NM-1:0] m_rd_bar_haz_in, m_wr_bar_haz_in, m_wr_trk_full_in, m_rd_lo_full_in;
  logic [NM-1:0] m_rd_med_full_in, m_wu_addr_haz_in, m_rd_secure_in, m_wr_secure_in;
  logic [NM*PEE_NUM_VN-1:0] m_rd_vn_wait_in, m_wr_vn_wait_in;
  logic [PEE_ID_W-1:0] count_select_in;
  logic [PEE_VEC_W-1:0] perf_event_vector_out, exp_vec;
  logic count_event_out;
  logic [31:0] seen_total;
  int n_errors, samples_checked, cycles, exp_total;
  typedef struct {int k; int p; int j; logic sec; logic sen;
                  logic [7:0] id; logic pass;} pee_row_type;
  pee_row_type rows [21] = '{
    '{0, 0, 3, 0, 0, 8'h03, 1}, '{0, 4, 8, 1, 0, 8'h88, 0}, '{0, 2, 1, 1, 1, 8'h41, 1},
    '{1, 1, 0, 0, 0, 8'h29, 1}, '{2, 3, 0, 1, 1, 8'h6A, 1}, '{3, 2, 0, 0, 0, 8'h4B, 1},
    '{4, 4, 6, 1, 0, 8'h92, 0}, '{5, 0, 0, 0, 0, 8'h13, 1}, '{6, 1, 0, 0, 0, 8'h34, 1},
    '{7, 0, 3, 0, 0, 8'hA0, 1}, '{7, 2, 1, 1, 0, 8'hE0, 0}, '{8, 1, 0, 1, 1, 8'hC1, 1},
    '{9, 2, 0, 1, 0, 8'hE2, 1}, '{10, 0, 0, 0, 0, 8'hA3, 1}, '{11, 1, 0, 0, 0, 8'hC4, 1},
    '{12, 2, 0, 0, 0, 8'hE5, 1}, '{13, 0, 0, 1, 1, 8'hA6, 1}, '{14, 1, 0, 0, 0, 8'hC7, 1},
    '{15, 2, 0, 1, 0, 8'hE8, 0}, '{16, 0, 0, 1, 0, 8'hA9, 1}, '{18, 2, 0, 0, 0, 8'hF1, 1}};

  pee_top i_pee_top (.clk_in, .rst_in, .noninvasive_monitor_enable_in, .secure_count_enable_in,
    .s_rd_hs_in, .s_rd_kind_in, .s_rd_secure_in, .s_rd_trk_stall_in, .s_rd_id_haz_stall_in,
    .s_rdata_last_hs_in, .s_rdata_from_snoop_in, .s_rdata_secure_in, .slave_port_read_valid_in,
    .slave_port_read_ready_in, .s_wr_hs_in, .s_wr_kind_in, .s_wr_secure_in, .s_wr_trk_stall_in,
    .m_retry_sched_in, .m_retry_secure_in, .m_rd_addr_haz_in, .m_rd_id_haz_in, .m_rd_hi_full_in,
    .m_rd_bar_haz_in, .m_wr_bar_haz_in, .m_wr_trk_full_in, .m_rd_lo_full_in, .m_rd_med_full_in,
    .m_rd_vn_wait_in, .m_wr_vn_wait_in, .m_wu_addr_haz_in, .m_rd_secure_in, .m_wr_secure_in,
    .count_select_in, .perf_event_vector_out, .count_event_out);
  pee_event_monitor i_pee_event_monitor (.clk_in, .rst_in,
    .perf_event_vector_in(perf_event_vector_out), .pulse_total_out(seen_total));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Vector bit of an event id: slave groups of 21, then master groups of 18
  function automatic int bit_of(input logic [7:0] id);
    if (id[7:5] < 3'h5) return int'(id[7:5]) * 21 + int'(id[4:0]);
    return 105 + (int'(id[7:5]) - 5) * 18 + int'(id[4:0]);
  endfunction : bit_of

  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic cmp_vec(input string name, input logic [PEE_VEC_W-1:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_vec

  task automatic cmp_word(input string name, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp_word

  // Clears every source, then raises one; ready idles high so valid alone never stalls
  task automatic drive(input int k, p, j, input logic sec);
    {s_rd_hs_in, s_rd_secure_in, s_rd_trk_stall_in, s_rd_id_haz_stall_in, s_rdata_last_hs_in,
     s_rdata_from_snoop_in, s_rdata_secure_in, slave_port_read_valid_in, s_wr_hs_in,
     s_wr_secure_in, s_wr_trk_stall_in, s_rd_kind_in, s_wr_kind_in, m_retry_sched_in,
     m_retry_secure_in, m_rd_addr_haz_in, m_rd_id_haz_in, m_rd_hi_full_in, m_rd_bar_haz_in,
     m_wr_bar_haz_in, m_wr_trk_full_in, m_rd_lo_full_in, m_rd_med_full_in, m_wu_addr_haz_in,
     m_rd_secure_in, m_wr_secure_in, m_rd_vn_wait_in, m_wr_vn_wait_in} = '0;
    slave_port_read_ready_in = '1;
    if (k >= 0 && k < 7) begin
      {s_rd_secure_in[p], s_rdata_secure_in[p], s_wr_secure_in[p]} = {3{sec}};
    end else if (k >= 7) begin
      {m_retry_secure_in[p], m_rd_secure_in[p], m_wr_secure_in[p]} = {3{sec}};
    end
    case (k)
      0: {s_rd_hs_in[p], s_rd_kind_in[p*PEE_S_RD_KINDS+j]} = {1'b1, j != 0};
      1: s_rd_trk_stall_in[p] = 1'b1;
      2: {s_rdata_last_hs_in[p], s_rdata_from_snoop_in[p]} = 2'h3;
      3: {slave_port_read_valid_in[p], slave_port_read_ready_in[p]} = 2'h2;
      4: begin
        s_wr_hs_in[p] = 1'b1;
        if (j != 0) s_wr_kind_in[p*(PEE_S_WR_KINDS-1)+j-1] = 1'b1;
      end
      5: s_wr_trk_stall_in[p] = 1'b1;
      6: s_rd_id_haz_stall_in[p] = 1'b1;
      7: m_retry_sched_in[2*p +: 2] = 2'(j);
      8: m_rd_addr_haz_in[p] = 1'b1;
      9: m_rd_id_haz_in[p] = 1'b1;
      10: m_rd_hi_full_in[p] = 1'b1;
      11: m_rd_bar_haz_in[p] = 1'b1;
      12: m_wr_bar_haz_in[p] = 1'b1;
      13: m_wr_trk_full_in[p] = 1'b1;
      14: m_rd_lo_full_in[p] = 1'b1;
      15: m_rd_med_full_in[p] = 1'b1;
      16: m_rd_vn_wait_in[p*PEE_NUM_VN+j] = 1'b1;
      17: m_wr_vn_wait_in[p*PEE_NUM_VN+j] = 1'b1;
      18: m_wu_addr_haz_in[p] = 1'b1;
      default: ;
    endcase
  endtask : drive

  // One event for one cycle: bit and selected count high once, then low again
  task automatic run(input int k, p, j, input logic sec, sen, men, input logic [7:0] id,
                     input logic pass);
    int b;
    b = bit_of(id);
    @(negedge clk_in);
    drive(k, p, j, sec);
    {secure_count_enable_in, noninvasive_monitor_enable_in, count_select_in} = {sen, men, id};
    exp_vec = '0;
    if (pass && men) begin
      exp_vec[b] = 1'b1;
      if (k == 0) exp_vec[bit_of(id & 8'hE0)] = 1'b1;
      if (k == 4) exp_vec[bit_of((id & 8'hE0) | 8'h0C)] = 1'b1;
    end
    @(negedge clk_in);
    cmp_vec("vector", exp_vec, perf_event_vector_out);
    cmp_word("count_event", 32'(exp_vec[b]), 32'(count_event_out));
    exp_total += $countones(exp_vec);
    drive(-1, 0, 0, 1'b0);
    @(negedge clk_in);
    cmp_vec("vector_idle", '0, perf_event_vector_out);
  endtask : run

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Hang guard, well above the roughly 160 cycles the sequence needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    rst_in = 1'b1;
    {noninvasive_monitor_enable_in, secure_count_enable_in, count_select_in} = '0;
    drive(-1, 0, 0, 1'b0);
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    foreach (rows[i]) run(rows[i].k, rows[i].p, rows[i].j, rows[i].sec, rows[i].sen, 1'b1,
                          rows[i].id, rows[i].pass);
    for (int j = 0; j < 9; j++) run(0, 1, j, 1'b0, 1'b0, 1'b1, 8'(8'h20 + j), 1'b1);
    for (int j = 0; j < 7; j++) run(4, 3, j, 1'b1, 1'b1, 1'b1, 8'(8'h6C + j), 1'b1);
    for (int j = 0; j < 4; j++) run(16, 1, j, 1'b0, 1'b0, 1'b1, 8'(8'hC9 + j), 1'b1);
    for (int j = 0; j < 4; j++) run(17, 2, j, 1'b0, 1'b0, 1'b1, 8'(8'hED + j), 1'b1);
    run(9, 0, 0, 1'b0, 1'b1, 1'b0, 8'hA2, 1'b1);
    run(0, 2, 5, 1'b1, 1'b1, 1'b0, 8'h45, 1'b1);
    // Stall held three cycles gives three pulses on slave port 4
    @(negedge clk_in);
    drive(3, 4, 0, 1'b0);
    noninvasive_monitor_enable_in = 1'b1;
    exp_vec = '0;
    exp_vec[bit_of(8'h8B)] = 1'b1;
    repeat (3) begin
      @(negedge clk_in);
      cmp_vec("held_stall", exp_vec, perf_event_vector_out);
    end
    drive(-1, 0, 0, 1'b0);
    exp_total += 3;
    repeat (2) @(negedge clk_in);
    cmp_word("pulse_total", 32'(exp_total), seen_total);
    // Reset in mid-event clears the vector at once
    drive(1, 0, 0, 1'b0);
    @(negedge clk_in);
    rst_in = 1'b1;
    #1;
    cmp_vec("vector_in_reset", '0, perf_event_vector_out);
    conclude();
  end
endmodule : pee_top_tb
